// ### logic/rpsl_regs.svh
// Purpose: constants of the rotary position scale and limit block
// Assumes: 100 MHz clk_in, word registers on a plain strobe port
// Notes:   all offsets are byte addresses
// How it works
// [RQ1] 80 teeth of 32768 counts make 2621440 counts per revolution.
// [RQ2] position is also shown in 0.01 degree units, 36000 per revolution.
// [RQ3] direction invert 0 counts cw up; 1 swaps both senses.
// [RQ4] inversion also reverses move directions and software limit sense.
// [RQ5] hardware limits ignore inversion: plus blocks cw, minus blocks ccw.
// [RQ6] zero set makes commanded position (actual plus error) the user home.
// [RQ7] home offset holds cw distance from motor home to user home.
// [RQ8] home offset resets to zero; software restores it after power-up.
// [RQ9] over-travel checks commanded position, never measured overshoot.
// [RQ10] forbidden area runs upward plus to minus; active if they differ.
// [RQ11] entering it latches over-travel, stops, allows only outward moves.
// [RQ12] over-travel closes both over-travel flag outputs.
// [RQ13] over-travel raises the soft over-travel alarm and servo lock.
// [RQ14] shortest absolute moves turn the other way to avoid the area.
// [RQ15] at power-up or servo off pick nearer limit; midway means plus.
// [RQ16] teaching loads measured position into a limit; direct write too.
// [RQ17] direction, zero set and limit writes need the password first.
// [RQ18] limits are held in count units only.
// [RQ19] position wraps from zero to one revolution minus one.
`ifndef RPSL_REGS_SVH
`define RPSL_REGS_SVH
`define RPSL_TOOTH_COUNTS  22'd32768
`define RPSL_TEETH         22'd80
`define RPSL_COUNTS_REV    (`RPSL_TOOTH_COUNTS * `RPSL_TEETH)
`define RPSL_HALF_REV      (`RPSL_COUNTS_REV >> 1)
`define RPSL_DEG_REV       16'd36000
`define RPSL_DEG_MUL       9'd225
`define RPSL_DEG_SHIFT     14
`define RPSL_ADDR_CTRL     6'h00
`define RPSL_ADDR_KEY      6'h04
`define RPSL_ADDR_CMD      6'h08
`define RPSL_ADDR_HOME     6'h0c
`define RPSL_ADDR_PLUS     6'h10
`define RPSL_ADDR_MINUS    6'h14
`define RPSL_ADDR_POS      6'h18
`define RPSL_ADDR_DEG      6'h1c
`define RPSL_ADDR_STAT     6'h20
`define RPSL_ADDR_IRQ      6'h24
`define RPSL_ADDR_MASK     6'h28
`define RPSL_ADDR_MOVE     6'h2c
`define RPSL_CMD_ZERO      0
`define RPSL_CMD_TEACH_P   1
`define RPSL_CMD_TEACH_M   2
`define RPSL_IRQ_OT        0
`define RPSL_IRQ_REJECT    1
`define RPSL_IRQ_ZERO      2
`define RPSL_ALARM_SOFT_OT 8'hf2
`define RPSL_KEY_VALUE     32'h5a5a_c3c3
`endif

// ### logic/rpsl_pkg.sv
// Purpose: types of the rotary position scale and limit block
// Assumes: constants live in rpsl_regs.svh
// Notes:   over-travel codes are gray along clear, plus, minus
package rpsl_pkg;
  typedef enum logic [1:0] {
    OT_CLEAR = 2'b00,
    OT_PLUS  = 2'b01,
    OT_MINUS = 2'b11
  } rpsl_ot_e;
  typedef enum logic [1:0] {
    MV_SHORT = 2'b00,
    MV_PLUS  = 2'b01,
    MV_MINUS = 2'b10
  } rpsl_move_e;
  typedef logic [21:0] rpsl_count_t;
endpackage : rpsl_pkg

// ### logic/rpsl_sync2.sv
// Purpose: two-flop synchroniser for pin inputs
// Assumes: each bit is sampled independently
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module rpsl_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      meta_reg <= '0;
      q_out    <= '0;
    end
    else
    begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : rpsl_sync2

// ### logic/rpsl_degree.sv
// Purpose: count to 0.01 degree conversion, registered
// Assumes: count below one revolution
// Notes:   36000 / 2621440 reduces to 225 / 16384
`timescale 1ns/1ps
`include "rpsl_regs.svh"
module rpsl_degree (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [21:0] count_in,
  output logic      [15:0] degree_out
);
  logic [30:0] prod;
  logic [15:0] degree_next;
  always_comb
  begin
    prod        = {9'h000, count_in} * {22'h000000, `RPSL_DEG_MUL};
    degree_next = prod[`RPSL_DEG_SHIFT +: 16]; // see [RQ2]
  end
  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      degree_out <= 16'h0000;
    else
      degree_out <= degree_next;
  end
endmodule : rpsl_degree

// ### logic/rpsl_top.sv
// Purpose: position scale, home offset and software over-travel logic
// Assumes: sensor gives raw cw count from motor home; error is signed
// Notes:   registers on a plain strobe port, read data one cycle later
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "rpsl_regs.svh"
module rpsl_top (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [21:0] sensor_pos_in,
  input  wire logic [23:0] pos_error_in,
  input  wire logic        servo_on_in,
  input  wire logic        plus_hw_limit_in,
  input  wire logic        minus_hw_limit_in,
  input  wire logic [5:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_en_in,
  input  wire logic        rd_en_in,
  output logic      [31:0] rd_data_out,
  output rpsl_pkg::rpsl_count_t position_out,
  output logic      [15:0] degree_out,
  output logic      [7:0]  alarm_code_out,
  output logic             servo_lock_out,
  output logic             stop_out,
  output logic             plus_overtravel_flag_out,
  output logic             minus_overtravel_flag_out,
  output logic             cw_block_out,
  output logic             ccw_block_out,
  output logic             move_start_out,
  output logic             move_up_out,
  output logic      [21:0] move_target_out,
  output logic             irq_out
);
  import rpsl_pkg::*;

  function automatic logic [21:0] sub_m(input logic [21:0] a,
                                        input logic [21:0] b);
    logic [22:0] t;
    t = {1'b0, a} - {1'b0, b};
    if (t[22])
      t = t + {1'b0, `RPSL_COUNTS_REV};
    return t[21:0];
  endfunction : sub_m

  function automatic logic [21:0] add_m(input logic [21:0] a,
                                        input logic [21:0] b);
    logic [22:0] t;
    t = {1'b0, a} + {1'b0, b};
    if (t >= {1'b0, `RPSL_COUNTS_REV})                        // see [RQ1]
      t = t - {1'b0, `RPSL_COUNTS_REV};
    return t[21:0];
  endfunction : add_m

  logic [21:0] sens_s;
  logic [1:0]  hw_s;
  logic [21:0] cw_act, count_act, err_mod, cmd_pos, raw_cmd;
  logic [21:0] area_len, area_d, delta, dist_up, dist_dn;
  logic [23:0] err_abs;
  logic        area_on, in_area, near_plus, moving_up, moving_dn;
  logic        wr_key, wr_prot, prot_ok, zero_go, reject_ev;
  logic        mv_ok, mv_up_pick, cross_up, cross_dn;

  logic        dir_inv_reg, dir_inv_next;
  logic        key_ok_reg, key_ok_next;
  logic [21:0] home_offset_reg, home_offset_next;
  logic [21:0] plus_lim_reg, plus_lim_next;
  logic [21:0] minus_lim_reg, minus_lim_next;
  logic [21:0] cmd_prev_reg;
  logic        init_reg;
  rpsl_ot_e    ot_reg, ot_next;
  logic [2:0]  irq_stat_reg, irq_stat_next;
  logic [2:0]  irq_mask_reg, irq_mask_next;
  logic [31:0] rd_next;
  logic        mv_start_next, mv_up_next;
  logic [21:0] mv_target_next;

  rpsl_sync2 #(.W(22)) u_sens (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (sensor_pos_in),
    .q_out    (sens_s)
  );
  rpsl_sync2 #(.W(2)) u_hw (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     ({plus_hw_limit_in, minus_hw_limit_in}),
    .q_out    (hw_s)
  );
  rpsl_degree u_deg (
    .clk_in     (clk_in),
    .rst_b_in   (rst_b_in),
    .count_in   (position_out),
    .degree_out (degree_out)
  );

  // position scale and commanded position
  always_comb
  begin
    cw_act    = sub_m(sens_s, home_offset_reg);                // see [RQ7]
    count_act = dir_inv_reg ? sub_m(22'h000000, cw_act)
                            : cw_act;                   // see [RQ3] [RQ19]
    err_abs   = pos_error_in[23] ? (~pos_error_in + 24'h000001)
                                 : pos_error_in;
    err_mod   = pos_error_in[23] ? sub_m(22'h000000, err_abs[21:0])
                                 : err_abs[21:0];
    cmd_pos   = add_m(count_act, err_mod);                     // see [RQ6]
    raw_cmd   = add_m(sens_s, dir_inv_reg ? sub_m(22'h000000, err_mod)
                                          : err_mod);          // see [RQ7]
    area_len  = sub_m(minus_lim_reg, plus_lim_reg);
    area_on   = (area_len != 22'h000000);                     // see [RQ10]
    area_d    = sub_m(cmd_pos, plus_lim_reg);                  // see [RQ9]
    in_area   = area_on && (area_d != 22'h000000) && (area_d < area_len);
    near_plus = ({area_d, 1'b0} <= {1'b0, area_len});         // see [RQ15]
    delta     = sub_m(cmd_pos, cmd_prev_reg);
    moving_up = (delta != 22'h000000) && (delta < `RPSL_HALF_REV);
    moving_dn = (delta != 22'h000000) && !moving_up;
  end

  // over-travel state
  always_comb
  begin
    ot_next = ot_reg;
    unique case (ot_reg)
      OT_CLEAR:
        if (in_area)
        begin
          if (init_reg || !servo_on_in)
            ot_next = near_plus ? OT_PLUS : OT_MINUS;          // see [RQ15]
          else
            ot_next = moving_up ? OT_PLUS : OT_MINUS;         // see [RQ11]
        end
      OT_PLUS, OT_MINUS:
        if (!in_area)
          ot_next = OT_CLEAR;
        else if (!servo_on_in)
          ot_next = near_plus ? OT_PLUS : OT_MINUS;            // see [RQ15]
      default:
        ot_next = OT_CLEAR;
    endcase
  end

  // register writes, password and move planning
  always_comb
  begin
    dir_inv_next     = dir_inv_reg;
    home_offset_next = home_offset_reg;
    plus_lim_next    = plus_lim_reg;
    minus_lim_next   = minus_lim_reg;
    irq_mask_next    = irq_mask_reg;
    key_ok_next      = key_ok_reg;
    zero_go          = 1'b0;
    reject_ev        = 1'b0;
    wr_key  = wr_en_in && (addr_in == `RPSL_ADDR_KEY);
    wr_prot = wr_en_in && ((addr_in == `RPSL_ADDR_CTRL) ||
              (addr_in == `RPSL_ADDR_CMD) || (addr_in == `RPSL_ADDR_HOME) ||
              (addr_in == `RPSL_ADDR_PLUS) || (addr_in == `RPSL_ADDR_MINUS));
    prot_ok = wr_prot && key_ok_reg;                           // see [RQ17]
    if (wr_key)
      key_ok_next = (wr_data_in == `RPSL_KEY_VALUE);
    else if (wr_prot)
    begin
      key_ok_next = 1'b0;
      reject_ev   = !key_ok_reg;                               // see [RQ17]
    end
    if (prot_ok)
    begin
      unique case (addr_in)
        `RPSL_ADDR_CTRL:
          dir_inv_next = wr_data_in[0];                        // see [RQ3]
        `RPSL_ADDR_CMD:
        begin
          zero_go = wr_data_in[`RPSL_CMD_ZERO];
          if (wr_data_in[`RPSL_CMD_ZERO])
            home_offset_next = raw_cmd;                   // see [RQ6] [RQ7]
          if (wr_data_in[`RPSL_CMD_TEACH_P])
            plus_lim_next = count_act;                        // see [RQ16]
          if (wr_data_in[`RPSL_CMD_TEACH_M])
            minus_lim_next = count_act;                       // see [RQ16]
        end
        `RPSL_ADDR_HOME:
          home_offset_next = wr_data_in[21:0];                 // see [RQ8]
        `RPSL_ADDR_PLUS:
          plus_lim_next = wr_data_in[21:0];                   // see [RQ18]
        default:
          minus_lim_next = wr_data_in[21:0];                  // see [RQ18]
      endcase
    end
    if (wr_en_in && (addr_in == `RPSL_ADDR_MASK))
      irq_mask_next = wr_data_in[2:0];
    dist_up  = sub_m(wr_data_in[21:0], cmd_pos);
    dist_dn  = sub_m(cmd_pos, wr_data_in[21:0]);
    cross_up = area_on && (sub_m(plus_lim_reg, cmd_pos) < dist_up);
    cross_dn = area_on && (sub_m(cmd_pos, minus_lim_reg) < dist_dn);
    unique case (rpsl_move_e'(wr_data_in[25:24]))
      MV_PLUS:  mv_up_pick = 1'b1;
      MV_MINUS: mv_up_pick = 1'b0;
      default:
      begin
        mv_up_pick = dist_up <= `RPSL_HALF_REV;
        if (mv_up_pick && cross_up)
          mv_up_pick = 1'b0;                                  // see [RQ14]
        else if (!mv_up_pick && cross_dn)
          mv_up_pick = 1'b1;                                  // see [RQ14]
      end
    endcase
    mv_ok = wr_en_in && (addr_in == `RPSL_ADDR_MOVE) &&
            (wr_data_in[21:0] < `RPSL_COUNTS_REV) &&
            (wr_data_in[25:24] != 2'b11) &&
            !((ot_reg == OT_PLUS) && mv_up_pick) &&
            !((ot_reg == OT_MINUS) && !mv_up_pick);           // see [RQ11]
    if (wr_en_in && (addr_in == `RPSL_ADDR_MOVE) && !mv_ok)
      reject_ev = 1'b1;
    mv_start_next  = mv_ok;
    mv_up_next     = mv_ok ? mv_up_pick : move_up_out;
    mv_target_next = mv_ok ? wr_data_in[21:0] : move_target_out;
    irq_stat_next  = irq_stat_reg;
    if (wr_en_in && (addr_in == `RPSL_ADDR_IRQ))
      irq_stat_next = irq_stat_reg & ~wr_data_in[2:0];
    irq_stat_next = irq_stat_next | {zero_go, reject_ev,
                    (ot_reg == OT_CLEAR) && (ot_next != OT_CLEAR)};
  end

  // read mux
  always_comb
  begin
    rd_next = 32'h00000000;
    if (rd_en_in)
    begin
      unique case (addr_in)
        `RPSL_ADDR_CTRL:  rd_next[0]    = dir_inv_reg;
        `RPSL_ADDR_HOME:  rd_next[21:0] = home_offset_reg;
        `RPSL_ADDR_PLUS:  rd_next[21:0] = plus_lim_reg;
        `RPSL_ADDR_MINUS: rd_next[21:0] = minus_lim_reg;
        `RPSL_ADDR_POS:   rd_next[21:0] = position_out;
        `RPSL_ADDR_DEG:   rd_next[15:0] = degree_out;
        `RPSL_ADDR_STAT:
          rd_next = {16'h0000, alarm_code_out, 3'b000, key_ok_reg,
                     area_on, ot_reg == OT_MINUS, ot_reg == OT_PLUS,
                     ot_reg != OT_CLEAR};                     // see [RQ13]
        `RPSL_ADDR_IRQ:   rd_next[2:0]  = irq_stat_reg;
        `RPSL_ADDR_MASK:  rd_next[2:0]  = irq_mask_reg;
        default:          rd_next       = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
    begin
      dir_inv_reg      <= 1'b0;
      key_ok_reg       <= 1'b0;
      home_offset_reg  <= 22'h000000;
      plus_lim_reg     <= 22'h000000;
      minus_lim_reg    <= 22'h000000;
      cmd_prev_reg     <= 22'h000000;
      init_reg         <= 1'b1;
      ot_reg           <= OT_CLEAR;
      irq_stat_reg     <= 3'h0;
      irq_mask_reg     <= 3'h0;
      rd_data_out      <= 32'h00000000;
      position_out     <= 22'h000000;
      alarm_code_out   <= 8'h00;
      servo_lock_out   <= 1'b0;
      stop_out         <= 1'b0;
      plus_overtravel_flag_out  <= 1'b0;
      minus_overtravel_flag_out <= 1'b0;
      cw_block_out     <= 1'b0;
      ccw_block_out    <= 1'b0;
      move_start_out   <= 1'b0;
      move_up_out      <= 1'b0;
      move_target_out  <= 22'h000000;
      irq_out          <= 1'b0;
    end
    else
    begin
      dir_inv_reg      <= dir_inv_next;
      key_ok_reg       <= key_ok_next;
      home_offset_reg  <= home_offset_next;
      plus_lim_reg     <= plus_lim_next;
      minus_lim_reg    <= minus_lim_next;
      cmd_prev_reg     <= cmd_pos;
      init_reg         <= 1'b0;
      ot_reg           <= ot_next;
      irq_stat_reg     <= irq_stat_next;
      irq_mask_reg     <= irq_mask_next;
      rd_data_out      <= rd_next;
      position_out     <= count_act;                          // see [RQ19]
      alarm_code_out   <= (ot_next != OT_CLEAR) ? `RPSL_ALARM_SOFT_OT
                                                : 8'h00;      // see [RQ13]
      servo_lock_out   <= ot_next != OT_CLEAR;                // see [RQ13]
      stop_out         <= ((ot_next == OT_PLUS) && moving_up) ||
                          ((ot_next == OT_MINUS) && moving_dn); // see [RQ11]
      plus_overtravel_flag_out  <= ot_next != OT_CLEAR;       // see [RQ12]
      minus_overtravel_flag_out <= ot_next != OT_CLEAR;       // see [RQ12]
      cw_block_out     <= hw_s[1] || (dir_inv_reg ? ot_next == OT_MINUS
                                      : ot_next == OT_PLUS); // see [RQ4] [RQ5]
      ccw_block_out    <= hw_s[0] || (dir_inv_reg ? ot_next == OT_PLUS
                                      : ot_next == OT_MINUS); // see [RQ5]
      move_start_out   <= mv_start_next;
      move_up_out      <= mv_up_next;
      move_target_out  <= mv_target_next;
      irq_out          <= |(irq_stat_next & irq_mask_next);
    end
  end

  AST_WRAP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    position_out < `RPSL_COUNTS_REV) // see [RQ19]
    else $error("position out of revolution range");
  AST_DEGREE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    degree_out < `RPSL_DEG_REV) // see [RQ2]
    else $error("degree out of range");
  AST_ALARM: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ot_reg != OT_CLEAR |-> alarm_code_out == `RPSL_ALARM_SOFT_OT &&
    servo_lock_out) // see [RQ13]
    else $error("over-travel without its alarm code");
  AST_FLAGS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ot_reg != OT_CLEAR) == (plus_overtravel_flag_out &&
    minus_overtravel_flag_out)) // see [RQ12]
    else $error("over-travel flags disagree with state");
  AST_KEY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_en_in && addr_in == `RPSL_ADDR_PLUS && !key_ok_reg
    |=> $stable(plus_lim_reg) && irq_stat_reg[`RPSL_IRQ_REJECT]) // see [RQ17]
    else $error("limit changed without password");
  AST_ZERO: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    zero_go |=> home_offset_reg == $past(raw_cmd) ##1
    position_out == 22'h000000 || pos_error_in != 24'h000000) // see [RQ6]
    else $error("zero set did not load commanded home");
  AST_CMD_ONLY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ot_reg == OT_CLEAR && !in_area |=> ot_reg == OT_CLEAR) // see [RQ9]
    else $error("over-travel raised outside commanded area");
  AST_AREA_OFF: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !area_on |=> ot_reg == OT_CLEAR) // see [RQ10]
    else $error("over-travel with equal limits");
  AST_MIDWAY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_area && !servo_on_in &&
    {area_d, 1'b0} == {1'b0, area_len} |=> ot_reg == OT_PLUS) // see [RQ15]
    else $error("midway entry not taken as plus side");
  AST_HW_CW: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    hw_s[1] |=> cw_block_out) // see [RQ5]
    else $error("plus hardware limit did not block cw");
  AST_OUTWARD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    move_start_out |-> !($past(ot_reg) == OT_PLUS && move_up_out)) // see [RQ11]
    else $error("move into area accepted");
endmodule : rpsl_top

// ### sim/rpsl_sensor_model.sv
// Purpose: absolute position sensor and drive error seen by the block
// Assumes: bench sets the raw cw angle and the position error
// Notes:   angle wraps at one revolution; values only change on request
`timescale 1ns/1ps
`include "rpsl_regs.svh"
module rpsl_sensor_model (
  input  wire logic        clk_in,
  input  wire logic [21:0] angle_in,
  input  wire logic [23:0] lag_in,
  output logic      [21:0] sensor_pos_out,
  output logic      [23:0] pos_error_out
);
  // held for many cycles so the pin synchroniser sees a stable word
  always_ff @(posedge clk_in)
  begin
    sensor_pos_out <= (angle_in >= `RPSL_COUNTS_REV) ?
                      angle_in - `RPSL_COUNTS_REV : angle_in;
    pos_error_out  <= lag_in;
  end
endmodule : rpsl_sensor_model

// ### sim/test_rotary_position_scale_limits.sv
// Purpose: self-checking bench of the position scale and limit block
// Assumes: limits in user counts, home offset in raw cw counts, servo on unless stated
// Notes:   one task per scenario, bus tasks on the strobe port
`timescale 1ns/1ps
`include "rpsl_regs.svh"
`define CHK(n, e, g) \
  begin checks_done++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module test_rotary_position_scale_limits;
  import rpsl_pkg::*;
  logic        clk_in      = 1'b0;
  logic        rst_b_in    = 1'b0;
  logic [21:0] angle       = '0;
  logic [23:0] lag         = '0;
  logic        servo_on    = 1'b0;
  logic        plus_hw     = 1'b0;
  logic        minus_hw    = 1'b0;
  logic [5:0]  addr        = '0;
  logic [31:0] wdata       = '0;
  logic        wr_en       = 1'b0;
  logic        rd_en       = 1'b0;
  logic [21:0] sensor_pos;
  logic [23:0] pos_err;
  logic [31:0] rd_data;
  rpsl_count_t position;
  logic [15:0] degree;
  logic [7:0]  alarm;
  logic        lock;
  logic        plus_flag;
  logic        minus_flag;
  logic        cw_blk;
  logic        ccw_blk;
  logic        mv_start;
  logic        mv_up;
  logic [21:0] mv_target;
  logic        irq;
  logic        stop;
  logic [31:0] rv;
  int          err_count   = 0;
  int          checks_done = 0;
  int          stop_cnt    = 0;

  always #5 clk_in = ~clk_in;

  // counts cycles in which the stop output stands
  always @(posedge clk_in)
    if (stop)
      stop_cnt++;

  rpsl_sensor_model u_rpsl_sensor_model (
    .clk_in(clk_in), .angle_in(angle), .lag_in(lag),
    .sensor_pos_out(sensor_pos), .pos_error_out(pos_err));

  rpsl_top u_rpsl_top (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .sensor_pos_in(sensor_pos),
    .pos_error_in(pos_err), .servo_on_in(servo_on),
    .plus_hw_limit_in(plus_hw), .minus_hw_limit_in(minus_hw),
    .addr_in(addr), .wr_data_in(wdata), .wr_en_in(wr_en),
    .rd_en_in(rd_en), .rd_data_out(rd_data), .position_out(position),
    .degree_out(degree), .alarm_code_out(alarm), .servo_lock_out(lock),
    .stop_out(stop), .plus_overtravel_flag_out(plus_flag),
    .minus_overtravel_flag_out(minus_flag), .cw_block_out(cw_blk),
    .ccw_block_out(ccw_blk), .move_start_out(mv_start),
    .move_up_out(mv_up), .move_target_out(mv_target), .irq_out(irq));

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_in);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a);
    @(posedge clk_in);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_in);
    rd_en <= 1'b0;
    #1 rv = rd_data;
  endtask : rd

  // key first, then the protected write
  task automatic pwr(input logic [5:0] a, input logic [31:0] d);
    wr(`RPSL_ADDR_KEY, `RPSL_KEY_VALUE);
    wr(a, d);
  endtask : pwr

  task automatic set_pos(input logic [21:0] a, input logic [23:0] e);
    @(posedge clk_in);
    angle <= a;
    lag   <= e;
    repeat (8) @(posedge clk_in);
    #1;
  endtask : set_pos

  // move pulse stands only in the cycle after the write
  task automatic chk_move(input logic [31:0] d, input logic up);
    wr(`RPSL_ADDR_MOVE, d);
    #1;
    `CHK("move start", 1'b1, mv_start)
    `CHK("move up", up, mv_up)
    `CHK("move target", d[21:0], mv_target)
    @(posedge clk_in);
    #1;
    `CHK("move pulse", 1'b0, mv_start)
  endtask : chk_move

  task automatic t_reset;
    rd(`RPSL_ADDR_STAT);
    `CHK("status", 32'h0, rv)
    rd(`RPSL_ADDR_HOME);
    `CHK("home", 32'h0, rv)
    `CHK("alarm", 8'h0, alarm)
  endtask : t_reset

  task automatic t_scale;
    set_pos(22'd655360, 24'h0);
    `CHK("pos", 22'd655360, position)
    `CHK("deg", 16'd9000, degree)
    set_pos(22'd2621439, 24'h0);
    `CHK("pos max", 22'd2621439, position)
    `CHK("deg max", 16'd35999, degree)
  endtask : t_scale

  task automatic t_reject;
    wr(`RPSL_ADDR_MASK, 32'h2);
    wr(`RPSL_ADDR_PLUS, 32'd77);
    rd(`RPSL_ADDR_PLUS);
    `CHK("plus no key", 32'h0, rv)
    `CHK("irq high", 1'b1, irq)
    wr(`RPSL_ADDR_IRQ, 32'h2);
    rd(`RPSL_ADDR_IRQ);
    `CHK("irq clear", 32'h0, rv)
    `CHK("irq low", 1'b0, irq)
    wr(`RPSL_ADDR_MOVE, 32'h0300_0000);
    rd(`RPSL_ADDR_IRQ);
    `CHK("bad mode", 32'h2, rv)
    wr(`RPSL_ADDR_IRQ, 32'h2);
    wr(`RPSL_ADDR_MOVE, 32'h0028_0000);
    rd(`RPSL_ADDR_IRQ);
    `CHK("bad target", 32'h2, rv)
    rd(6'h30);
    `CHK("unmapped", 32'h0, rv)
  endtask : t_reject

  task automatic t_zero;
    set_pos(22'd1000, 24'd24);
    pwr(`RPSL_ADDR_CMD, 32'h1);
    rd(`RPSL_ADDR_HOME);
    `CHK("home", 32'd1024, rv)
    set_pos(22'd1000, 24'd0);
    `CHK("pos wrap", 22'd2621416, position)
    rd(`RPSL_ADDR_IRQ);
    `CHK("zero done", 1'b1, rv[2])
    pwr(`RPSL_ADDR_HOME, 32'h0);
    set_pos(22'd1000, 24'd0);
    `CHK("pos home", 22'd1000, position)
  endtask : t_zero

  task automatic t_ot;
    pwr(`RPSL_ADDR_CMD, 32'h2);
    pwr(`RPSL_ADDR_MINUS, 32'd2000);
    rd(`RPSL_ADDR_PLUS);
    `CHK("teach plus", 32'd1000, rv)
    set_pos(22'd500, 24'd0);
    chk_move(32'h0000_09c4, 1'b0);
    set_pos(22'd1500, 24'hfffda8);
    `CHK("overshoot", 8'h0, alarm)
    set_pos(22'd1500, 24'd0);
    `CHK("alarm", 8'hf2, alarm)
    `CHK("flags", 3'b111, {plus_flag, minus_flag, lock})
    `CHK("stop", 1, stop_cnt)
    rd(`RPSL_ADDR_STAT);
    `CHK("status", 32'h0000_f20b, rv)
    wr(`RPSL_ADDR_IRQ, 32'h7);
    wr(`RPSL_ADDR_MOVE, 32'h0100_0708);
    rd(`RPSL_ADDR_IRQ);
    `CHK("deeper move", 1'b1, rv[1])
    chk_move(32'h0200_01f4, 1'b0);
    @(posedge clk_in);
    servo_on <= 1'b0;
    set_pos(22'd1800, 24'd0);
    rd(`RPSL_ADDR_STAT);
    `CHK("near minus", 32'h0000_f20d, rv)
    set_pos(22'd1500, 24'd0);
    rd(`RPSL_ADDR_STAT);
    `CHK("midway", 32'h0000_f20b, rv)
    @(posedge clk_in);
    servo_on <= 1'b1;
    set_pos(22'd500, 24'd0);
    `CHK("left area", 8'h0, alarm)
  endtask : t_ot

  task automatic t_invert;
    pwr(`RPSL_ADDR_CTRL, 32'h1);
    set_pos(22'd500, 24'd0);
    `CHK("inv pos", 22'd2620940, position)
    set_pos(22'd2619940, 24'd0);
    `CHK("inv soft blocks", 2'b01, {cw_blk, ccw_blk})
    set_pos(22'd500, 24'd0);
    @(posedge clk_in);
    plus_hw <= 1'b1;
    set_pos(22'd500, 24'd0);
    `CHK("hw blocks", 2'b10, {cw_blk, ccw_blk})
  endtask : t_invert

  task automatic final_report;
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    servo_on <= 1'b1;
    t_reset();
    t_scale();
    t_reject();
    t_zero();
    t_ot();
    t_invert();
    final_report();
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    final_report();
  end
endmodule : test_rotary_position_scale_limits
